// *** conv_pkg.sv ***
// constants, field layouts and types for the converter control block
// assumes a 100 MHz ref_clk and an 8-bit register port in front
package conv_pkg;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_MAKER_LO = 8'h0c;
    localparam logic [7:0] ADDR_MAKER_HI = 8'h0d;
    localparam logic [7:0] ADDR_TRANSFER = 8'h0f;
    localparam logic [7:0] ADDR_CONV_SETUP = 8'h10;
    localparam logic [7:0] ADDR_FILTER_SETUP = 8'h11;

    // ------------------------------------------------------------
    // reset values, identity bytes and command bits
    // ------------------------------------------------------------
    localparam logic [7:0] CONV_SETUP_RST = 8'h00;
    localparam logic [7:0] FILTER_SETUP_RST = 8'h70;
    localparam logic [7:0] TRANSFER_READ = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;
    localparam logic [7:0] MAKER_LO_DEF = 8'h5a; // arbitrary value
    localparam logic [7:0] MAKER_HI_DEF = 8'h3c; // arbitrary value
    localparam int DAC_UPDATE_BIT = 0;
    localparam int ADC_UPDATE_BIT = 4;

    // ------------------------------------------------------------
    // sample times and cycle counts
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int T_11P5_NS = 11500;
    localparam int T_23_NS = 23000;
    localparam int T_34P5_NS = 34500;
    localparam int T_69_NS = 69000;
    localparam int T_11P5_CYC = (T_11P5_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int T_23_CYC = (T_23_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int T_34P5_CYC = (T_34P5_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int T_69_CYC = (T_69_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CYC_W = 16;
    localparam int NEED_W = 9;

    // ------------------------------------------------------------
    // register layouts and states
    // ------------------------------------------------------------
    typedef struct packed {
        logic repeat_conversion_sel;
        logic [1:0] sample_time_sel;
        logic reference_buffer_on;
        logic [3:0] rsvd;
    } conv_setup_t;

    typedef struct packed {
        logic [2:0] channel_alarm_filter_depth;
        logic [1:0] thermal_alarm_filter_depth;
        logic [2:0] rsvd;
    } filter_setup_t;

    typedef enum logic {CONV_IDLE, CONV_SAMPLE} conv_state_t;

    // consecutive samples needed for a channel alarm
    function automatic logic [NEED_W-1:0] ch_need(input logic [2:0] code);
        ch_need = (code == 3'h0) ? 9'h001 : (9'h002 << code);
    endfunction

    // consecutive samples needed for the thermal alarm
    function automatic logic [NEED_W-1:0] temp_need(input logic [1:0] code);
        temp_need = 9'h001 << code;
    endfunction

endpackage

// *** sample_timer.sv ***
// down counter that times one channel sample
// assumes load is a one-cycle pulse with a value of at least one
`timescale 1ns/1ps
module sample_timer #(
    parameter int W = 16
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // control
    input wire logic load,
    input wire logic [W-1:0] load_val,
    output logic done
);
    logic [W-1:0] cnt_q;
    logic done_q;

    // ------------------------------------------------------------
    // count down, flag the last cycle
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            cnt_q <= '0;
            done_q <= 1'b0;
        end else begin
            done_q <= !load && (cnt_q == {{(W-1){1'b0}}, 1'b1});
            if (load)
                cnt_q <= load_val;
            else if (cnt_q != '0)
                cnt_q <= cnt_q - 1'b1;
        end
    end
    assign done = done_q;
endmodule

// *** alarm_filter.sv ***
// consecutive out-of-range filter for one alarm source
// assumes strobe marks one finished sample of this source
`timescale 1ns/1ps
module alarm_filter #(
    parameter int CW = 9
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // sample events
    input wire logic strobe,
    input wire logic out_of_range,
    input wire logic restart,
    input wire logic [CW-1:0] need,
    // result
    output logic alarm
);
    logic [CW-1:0] cnt_q;
    logic alarm_q;
    wire [CW:0] cnt_inc = {1'b0, cnt_q} + 1'b1;
    wire reached = cnt_inc >= {1'b0, need};

    // ------------------------------------------------------------
    // count a run of bad samples, alarm at the needed length
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            cnt_q <= '0;
            alarm_q <= 1'b0;
        end else if (restart) begin
            cnt_q <= '0;
            alarm_q <= 1'b0;
        end else if (strobe && out_of_range) begin
            if (reached)
                alarm_q <= 1'b1;
            else
                cnt_q <= cnt_inc[CW-1:0];
        end else if (strobe) begin
            cnt_q <= '0;
            alarm_q <= 1'b0;
        end
    end
    assign alarm = alarm_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_single_bad;
        @(posedge ref_clk) disable iff (!resetn)
        strobe && out_of_range && !restart && need == 1 |=> alarm;
    endproperty
    a_single_bad: assert property (p_single_bad)
        else $error("alarm not set after one bad sample");

    property p_good_clears;
        @(posedge ref_clk) disable iff (!resetn)
        strobe && !out_of_range |=> !alarm;
    endproperty
    a_good_clears: assert property (p_good_clears)
        else $error("alarm kept after a good sample");
endmodule

// *** conv_control.sv ***
// converter update and sequencing control, with alarm filters
// assumes the serial port delivers one-cycle register strobes
// and the converter hands one result per finished sample
//
// Overview of operation
// - two read-only maker code bytes, full eight bits, writes ignored.
// - writing one to bit 4 copies latest results to readable registers.
// - in repeat mode readable results change only on that copy command.
// - writing one to bit 0 moves all buffered DAC codes to active.
// - both command bits self clear and always read back as zero.
// - mode bit zero converts each enabled input once then idles.
// - mode bit one loops over enabled inputs without end.
// - sample time field picks unipolar and bipolar sample times.
// - reference buffer follows its setup bit, off until set.
// - channel filter depth field at bits 7-5, reset 011.
// - thermal filter depth field at bits 4-3, reset 10.
// - channel alarm needs 1 to 256 consecutive bad samples.
// - thermal alarm needs 1 to 8 consecutive bad samples.
`timescale 1ns/1ps
module conv_control #(
    parameter int NCH = 21,
    parameter int NBIP = 16,
    parameter int NDAC = 16,
    parameter int DW = 12,
    parameter int RW = 12,
    parameter logic [7:0] MAKER_LO = conv_pkg::MAKER_LO_DEF,
    parameter logic [7:0] MAKER_HI = conv_pkg::MAKER_HI_DEF,
    parameter int LONG_SAMPLE_CYC = conv_pkg::T_69_CYC
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // conversion sequencing
    input wire logic conv_trigger,
    input wire logic [NCH:0] chan_enable,
    output logic [$clog2(NCH+1)-1:0] mux_sel,
    output logic conv_busy,
    output logic reference_buffer_on,
    // converter results
    input wire logic [RW-1:0] sample_data,
    input wire logic out_of_range,
    input wire logic [$clog2(NCH+1)-1:0] result_sel,
    output logic [RW-1:0] result_data,
    // dac codes
    input wire logic [NDAC-1:0][DW-1:0] dac_buffer,
    output logic [NDAC-1:0][DW-1:0] dac_active,
    // alarms
    output logic [NCH-1:0] chan_alarm,
    output logic temp_alarm
);
    localparam int NSLOT = NCH + 1;
    localparam int SW = $clog2(NSLOT);
    localparam logic [SW-1:0] TEMP_SLOT = SW'(NCH);
    localparam logic [SW-1:0] BIP_LIMIT = SW'(NBIP);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // lowest enabled slot at or above start, with a found flag
    function automatic logic [SW:0] find_from(input logic [NSLOT-1:0] en,
                                              input logic [SW:0] start);
        logic [SW:0] hit;
        hit = '0;
        for (int i = NSLOT - 1; i >= 0; i--) begin
            if (en[i] && (SW+1)'(i) >= start)
                hit = {1'b1, SW'(i)};
        end
        return hit;
    endfunction

    // sample length in cycles for one setting and channel kind
    function automatic logic [conv_pkg::CYC_W-1:0] sample_cycles(
        input logic [1:0] sel, input logic bip);
        logic [conv_pkg::CYC_W-1:0] c;
        case (sel)
            2'h0: c = bip ? conv_pkg::CYC_W'(conv_pkg::T_34P5_CYC)
                          : conv_pkg::CYC_W'(conv_pkg::T_11P5_CYC);
            2'h1: c = bip ? conv_pkg::CYC_W'(conv_pkg::T_34P5_CYC)
                          : conv_pkg::CYC_W'(conv_pkg::T_23_CYC);
            2'h2: c = conv_pkg::CYC_W'(conv_pkg::T_34P5_CYC);
            default: c = conv_pkg::CYC_W'(LONG_SAMPLE_CYC);
        endcase
        return c;
    endfunction

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    conv_pkg::conv_setup_t setup_q;
    conv_pkg::filter_setup_t filter_q;
    logic [7:0] rdata_q;
    logic [NDAC-1:0][DW-1:0] dac_q;

    // write decode; command bits act in the write cycle, store nothing
    wire wr_transfer = reg_wr && reg_addr == conv_pkg::ADDR_TRANSFER;
    wire wr_setup = reg_wr && reg_addr == conv_pkg::ADDR_CONV_SETUP;
    wire wr_filter = reg_wr && reg_addr == conv_pkg::ADDR_FILTER_SETUP;
    wire dac_cmd = wr_transfer && reg_wdata[conv_pkg::DAC_UPDATE_BIT];
    wire adc_cmd = wr_transfer && reg_wdata[conv_pkg::ADC_UPDATE_BIT];

    // read selection; maker bytes are constants, writes never reach them
    wire [7:0] rd_word =
        (reg_addr == conv_pkg::ADDR_MAKER_LO) ? MAKER_LO :
        (reg_addr == conv_pkg::ADDR_MAKER_HI) ? MAKER_HI :
        (reg_addr == conv_pkg::ADDR_TRANSFER) ? conv_pkg::TRANSFER_READ :
        (reg_addr == conv_pkg::ADDR_CONV_SETUP) ? setup_q :
        (reg_addr == conv_pkg::ADDR_FILTER_SETUP) ? filter_q :
        conv_pkg::UNMAPPED_READ;

    // setup registers; reserved bits kept as written
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            setup_q <= conv_pkg::CONV_SETUP_RST;
            filter_q <= conv_pkg::FILTER_SETUP_RST;
        end else begin
            if (wr_setup)
                setup_q <= reg_wdata;
            if (wr_filter)
                filter_q <= reg_wdata;
        end
    end

    // read data, one cycle after the read strobe
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn)
            rdata_q <= '0;
        else if (reg_rd)
            rdata_q <= rd_word;
    end
    assign reg_rdata = rdata_q;

    // dac commit moves every buffered code at once
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn)
            dac_q <= '0;
        else if (dac_cmd)
            dac_q <= dac_buffer;
    end
    assign dac_active = dac_q;
    assign reference_buffer_on = setup_q.reference_buffer_on;

    // ------------------------------------------------------------
    // conversion sequencer
    // ------------------------------------------------------------
    conv_pkg::conv_state_t state_q;
    logic [SW-1:0] cur_q;
    logic tmr_load_q;
    logic [conv_pkg::CYC_W-1:0] tmr_val_q;
    logic tmr_done;
    logic seq_restart_q;

    wire [SW:0] first_hit = find_from(chan_enable, '0);
    wire [SW:0] next_hit = find_from(chan_enable, {1'b0, cur_q} + 1'b1);
    wire repeat_mode = setup_q.repeat_conversion_sel;
    wire start_seq = state_q == conv_pkg::CONV_IDLE && conv_trigger &&
                     first_hit[SW];
    wire wrap_seq = !next_hit[SW] && repeat_mode && first_hit[SW];
    wire [SW-1:0] go_slot = start_seq || wrap_seq ? first_hit[SW-1:0]
                                                 : next_hit[SW-1:0];
    wire go_bip = go_slot < BIP_LIMIT;
    wire go_on = start_seq || (state_q == conv_pkg::CONV_SAMPLE &&
                 tmr_done && (next_hit[SW] || wrap_seq));

    // walk the enabled slots; idle or loop at the end
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= conv_pkg::CONV_IDLE;
            cur_q <= '0;
            tmr_load_q <= 1'b0;
            tmr_val_q <= '0;
            seq_restart_q <= 1'b0;
        end else begin
            tmr_load_q <= go_on;
            seq_restart_q <= start_seq;
            if (go_on) begin
                cur_q <= go_slot;
                tmr_val_q <= sample_cycles(setup_q.sample_time_sel,
                                           go_bip);
            end
            case (state_q)
                conv_pkg::CONV_IDLE: begin
                    if (start_seq)
                        state_q <= conv_pkg::CONV_SAMPLE;
                end
                conv_pkg::CONV_SAMPLE: begin
                    if (tmr_done && !go_on)
                        state_q <= conv_pkg::CONV_IDLE;
                end
                default: state_q <= conv_pkg::CONV_IDLE;
            endcase
        end
    end
    assign mux_sel = cur_q;
    assign conv_busy = state_q == conv_pkg::CONV_SAMPLE;

    sample_timer #(
        .W(conv_pkg::CYC_W)
    ) u_timer (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .load(tmr_load_q),
        .load_val(tmr_val_q),
        .done(tmr_done)
    );

    // ------------------------------------------------------------
    // result storage: latest per slot and the readable copy
    // ------------------------------------------------------------
    logic [NSLOT-1:0][RW-1:0] live_q;
    logic [NSLOT-1:0][RW-1:0] shown_q;
    logic [RW-1:0] result_q;

    generate
        for (genvar s = 0; s < NSLOT; s++) begin : g_slot
            wire cap = tmr_done && state_q == conv_pkg::CONV_SAMPLE &&
                       cur_q == SW'(s);
            // direct mode shows results at once; repeat mode waits
            always_ff @(posedge ref_clk or negedge resetn) begin
                if (!resetn) begin
                    live_q[s] <= '0;
                    shown_q[s] <= '0;
                end else begin
                    if (cap)
                        live_q[s] <= sample_data;
                    if (cap && !repeat_mode)
                        shown_q[s] <= sample_data;
                    else if (adc_cmd)
                        shown_q[s] <= live_q[s];
                end
            end
        end
    endgenerate

    // registered readout of one readable result
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn)
            result_q <= '0;
        else
            result_q <= shown_q[result_sel];
    end
    assign result_data = result_q;

    // ------------------------------------------------------------
    // alarm filters
    // ------------------------------------------------------------
    wire [conv_pkg::NEED_W-1:0] ch_n =
        conv_pkg::ch_need(filter_q.channel_alarm_filter_depth);
    wire [conv_pkg::NEED_W-1:0] temp_n =
        conv_pkg::temp_need(filter_q.thermal_alarm_filter_depth);
    wire samp_done = tmr_done && state_q == conv_pkg::CONV_SAMPLE;

    generate
        for (genvar c = 0; c < NCH; c++) begin : g_alarm
            alarm_filter #(
                .CW(conv_pkg::NEED_W)
            ) u_filt (
                .ref_clk(ref_clk),
                .resetn(resetn),
                .strobe(samp_done && cur_q == SW'(c)),
                .out_of_range(out_of_range),
                .restart(seq_restart_q),
                .need(ch_n),
                .alarm(chan_alarm[c])
            );
        end
    endgenerate

    alarm_filter #(
        .CW(conv_pkg::NEED_W)
    ) u_temp_filt (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .strobe(samp_done && cur_q == TEMP_SLOT),
        .out_of_range(out_of_range),
        .restart(seq_restart_q),
        .need(temp_n),
        .alarm(temp_alarm)
    );

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    sequence s_last_done;
        samp_done && !next_hit[SW];
    endsequence

    property p_maker_lo;
        reg_rd && reg_addr == conv_pkg::ADDR_MAKER_LO |=>
            reg_rdata == MAKER_LO;
    endproperty
    a_maker_lo: assert property (p_maker_lo)
        else $error("maker low byte read wrong");

    property p_dac_commit;
        dac_cmd |=> dac_active == $past(dac_buffer);
    endproperty
    a_dac_commit: assert property (p_dac_commit)
        else $error("dac codes not committed");

    property p_dac_hold;
        !dac_cmd |=> $stable(dac_active);
    endproperty
    a_dac_hold: assert property (p_dac_hold)
        else $error("dac codes moved without command");

    property p_cmd_reads_zero;
        reg_rd && reg_addr == conv_pkg::ADDR_TRANSFER |=> reg_rdata == 8'h00;
    endproperty
    a_cmd_reads_zero: assert property (p_cmd_reads_zero)
        else $error("transfer register did not read zero");

    property p_repeat_hold;
        repeat_mode && !adc_cmd |=> $stable(shown_q);
    endproperty
    a_repeat_hold: assert property (p_repeat_hold)
        else $error("readable results changed without command");

    property p_adc_copy;
        adc_cmd && !samp_done |=> shown_q == $past(live_q);
    endproperty
    a_adc_copy: assert property (p_adc_copy)
        else $error("results not copied on command");

    property p_ref_buf;
        wr_setup ##1 !wr_setup |-> reference_buffer_on == $past(reg_wdata[4]);
    endproperty
    a_ref_buf: assert property (p_ref_buf)
        else $error("reference buffer does not follow setup");

    property p_direct_stops;
        s_last_done and !repeat_mode |=> !conv_busy;
    endproperty
    a_direct_stops: assert property (p_direct_stops)
        else $error("direct mode did not go idle");

    property p_repeat_loops;
        s_last_done and repeat_mode and first_hit[SW] |=>
            conv_busy && mux_sel == $past(first_hit[SW-1:0]);
    endproperty
    a_repeat_loops: assert property (p_repeat_loops)
        else $error("repeat mode did not wrap");

    property p_sample_len;
        go_on && setup_q.sample_time_sel == 2'h0 && !go_bip |=>
            tmr_val_q == conv_pkg::CYC_W'(conv_pkg::T_11P5_CYC);
    endproperty
    a_sample_len: assert property (p_sample_len)
        else $error("wrong unipolar sample length");

    property p_restart;
        start_seq |=> seq_restart_q;
    endproperty
    a_restart: assert property (p_restart)
        else $error("filters not restarted on new sequence");
endmodule

// *** conv_control_tb.sv ***
// self-checking bench for the converter control block
// assumes conv_pkg is compiled first; drives the register strobe port
`timescale 1ns/1ps
module conv_control_tb;
    localparam int LONG = 20;
    logic ref_clk, resetn, reg_wr, reg_rd, conv_trigger, out_of_range;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic [21:0] chan_enable;
    logic [4:0] mux_sel, result_sel;
    logic conv_busy, reference_buffer_on, temp_alarm;
    logic [11:0] sample_data, result_data;
    logic [15:0][11:0] dac_buffer, dac_active, dac_old;
    logic [20:0] chan_alarm;
    int n_errors, check_count;

    // ----------------------------------------
    // device under test
    // ----------------------------------------
    conv_control #(.LONG_SAMPLE_CYC(LONG)) DUT (
        .ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .conv_trigger(conv_trigger),
        .chan_enable(chan_enable), .mux_sel(mux_sel),
        .conv_busy(conv_busy), .reference_buffer_on(reference_buffer_on),
        .sample_data(sample_data), .out_of_range(out_of_range),
        .result_sel(result_sel), .result_data(result_data),
        .dac_buffer(dac_buffer), .dac_active(dac_active),
        .chan_alarm(chan_alarm), .temp_alarm(temp_alarm));

    // ----------------------------------------
    // clock, compare and port tasks
    // ----------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected reg at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_val(input logic [191:0] got, input logic [191:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected val at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge ref_clk);
        reg_wr = 1'b0;
    endtask

    task automatic read_chk(input logic [7:0] a, input logic [7:0] exp);
        @(negedge ref_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge ref_clk);
        reg_rd = 1'b0;
        chk_reg(reg_rdata, exp);
    endtask

    // pulse the trigger for one cycle
    task automatic trigger();
        @(negedge ref_clk);
        conv_trigger = 1'b1;
        @(negedge ref_clk);
        conv_trigger = 1'b0;
    endtask

    // wait until the sequencer moves off a slot, then let results land
    task automatic wait_leave(input logic [4:0] slot);
        int k;
        k = 0;
        while (mux_sel !== slot && k < 9000) begin
            @(negedge ref_clk);
            k++;
        end
        while (mux_sel === slot && k < 9000) begin
            @(negedge ref_clk);
            k++;
        end
        chk_val(192'(k < 9000), 192'(1'b1));
        repeat (3) @(negedge ref_clk);
    endtask

    // one direct pass over slot 20, busy length against sample time
    task automatic run_direct(input logic [1:0] sel, input int exp);
        int cnt;
        reg_write(conv_pkg::ADDR_CONV_SETUP, {1'b0, sel, 5'h10});
        trigger();
        chk_val(192'({conv_busy, mux_sel}), 192'({1'b1, 5'h14}));
        cnt = 1;
        while (conv_busy === 1'b1 && cnt < 8000) begin
            @(negedge ref_clk);
            cnt++;
        end
        chk_val(192'(cnt >= exp && cnt <= exp + 6), 192'(1'b1));
        repeat (30) @(negedge ref_clk);
        chk_val(192'(conv_busy), 192'(1'b0));
        chk_val(192'(result_data), 192'(12'habc));
    endtask

    task automatic print_verdict();
        $display("errors=%0d checks=%0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // ----------------------------------------
    // watchdog and main sequence
    // ----------------------------------------
    initial begin
        repeat (40000) @(posedge ref_clk);
        n_errors++;
        $display("unexpected timeout at %0t", $time);
        print_verdict();
    end

    initial begin
        n_errors = 0;
        check_count = 0;
        {resetn, reg_wr, reg_rd, conv_trigger, out_of_range} = 5'h00;
        {reg_addr, reg_wdata, chan_enable, result_sel} = 43'h0;
        sample_data = 12'habc;
        for (int i = 0; i < 16; i++) dac_buffer[i] = 12'(i * 7 + 1);
        repeat (4) @(posedge ref_clk);
        @(negedge ref_clk);
        resetn = 1'b1;
        read_chk(conv_pkg::ADDR_MAKER_LO, conv_pkg::MAKER_LO_DEF);
        read_chk(conv_pkg::ADDR_MAKER_HI, conv_pkg::MAKER_HI_DEF);
        read_chk(conv_pkg::ADDR_CONV_SETUP, 8'h00);
        read_chk(conv_pkg::ADDR_FILTER_SETUP, 8'h70);
        read_chk(conv_pkg::ADDR_TRANSFER, 8'h00);
        chk_val(192'(reference_buffer_on), 192'(1'b0));
        reg_write(conv_pkg::ADDR_MAKER_LO, 8'hff);
        reg_write(conv_pkg::ADDR_MAKER_HI, 8'h00);
        read_chk(conv_pkg::ADDR_MAKER_LO, conv_pkg::MAKER_LO_DEF);
        read_chk(conv_pkg::ADDR_MAKER_HI, conv_pkg::MAKER_HI_DEF);
        read_chk(8'h20, conv_pkg::UNMAPPED_READ);
        reg_write(conv_pkg::ADDR_FILTER_SETUP, 8'he0);
        read_chk(conv_pkg::ADDR_FILTER_SETUP, 8'he0);
        reg_write(conv_pkg::ADDR_CONV_SETUP, 8'h10);
        chk_val(192'(reference_buffer_on), 192'(1'b1));
        // dac commit: zero does nothing, one copies, command self clears
        reg_write(conv_pkg::ADDR_TRANSFER, 8'h00);
        chk_val(192'(dac_active), 192'(0));
        reg_write(conv_pkg::ADDR_TRANSFER, 8'h01);
        chk_val(192'(dac_active), 192'(dac_buffer));
        read_chk(conv_pkg::ADDR_TRANSFER, 8'h00);
        dac_old = dac_buffer;
        dac_buffer = ~dac_buffer;
        repeat (3) @(negedge ref_clk);
        chk_val(192'(dac_active), 192'(dac_old));
        reg_write(conv_pkg::ADDR_TRANSFER, 8'h01);
        chk_val(192'(dac_active), 192'(dac_buffer));
        // direct passes over every sample time code
        chan_enable = 22'h100000;
        result_sel = 5'd20;
        run_direct(2'd0, conv_pkg::T_11P5_CYC);
        run_direct(2'd1, conv_pkg::T_23_CYC);
        run_direct(2'd2, conv_pkg::T_34P5_CYC);
        run_direct(2'd3, LONG);
        // repeat mode with alarm filters: channel needs 4, thermal 2
        reg_write(conv_pkg::ADDR_FILTER_SETUP, 8'h28);
        reg_write(conv_pkg::ADDR_CONV_SETUP, 8'hf0);
        chan_enable = 22'h200001;
        result_sel = 5'd0;
        sample_data = 12'h123;
        out_of_range = 1'b1;
        trigger();
        for (int i = 1; i <= 4; i++) begin
            wait_leave(5'd0);
            chk_val(192'(chan_alarm[0]), 192'(i == 4));
            chk_val(192'(result_data), 192'(0));
            wait_leave(5'd21);
            chk_val(192'(temp_alarm), 192'(i >= 2));
            chk_val(192'(mux_sel), 192'(5'd0));
        end
        reg_write(conv_pkg::ADDR_TRANSFER, 8'h10);
        @(negedge ref_clk);
        chk_val(192'(result_data), 192'(12'h123));
        print_verdict();
    end
endmodule
